/* File: rtl/asa_link_if.sv */
`timescale 1ns/1ps
// Backplane timing lines shared by the module and its peers.
interface asa_link_if;
    logic ref_clk;          // Reference clock made by the backplane end.
    logic dev_sync_drive;   // Module drives the sync pulse line high.
    logic dev_start_drive;  // Module drives the start trigger line high.
    logic peer_sync_drive;  // Peer drives the sync pulse line high.
    logic peer_start_drive; // Peer drives the start trigger line high.
    logic sync_line;        // Resolved sync pulse line.
    logic start_line;       // Resolved start trigger line.

    // Bused lines behave as a wired OR of all drivers.
    assign sync_line  = dev_sync_drive | peer_sync_drive;
    assign start_line = dev_start_drive | peer_start_drive;

    modport dev  (input ref_clk, sync_line, start_line, output dev_sync_drive, dev_start_drive);
    modport peer (input sync_line, start_line, output ref_clk, peer_sync_drive, peer_start_drive);
endinterface

/* File: rtl/asa_module.sv */
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Oversample clock follows backplane reference when selected.
// [RULE2] Sync pulse resets converters and oversample dividers.
// [RULE3] Sync master drives line; slaves take it.
// [RULE4] Start master drives start; slaves accept it.
// [RULE5] Role bit: master originates, slave follows start.
// [RULE6] Report settle time; master waits start floor.
// [RULE7] Slaves arm first; master commit emits sync.
// [RULE8] Slaves start first; master start releases data.
// [RULE9] Data delayed by filter group delay compensation.
// [RULE10] Four independent timing engines run concurrently.
// [RULE11] Engine uses stream of its sample mode.
// [RULE12] Four streams per mode, eight channels each.
// [RULE13] All thirty-two channels convert on one strobe.
// [RULE14] Four banks of eight share one mode.
// [RULE15] Crosspoint: any channels, bank mode must match.
// [RULE16] Already claimed channel request is rejected.
// [RULE17] Request against other bank mode rejected.
// [RULE18] No free engine rejects any request.
// [RULE19] Streams of a mode exhausted rejects request.
// [RULE20] Start source and edge are selectable.
// [RULE21] Start accepted only after group delay elapsed.
// [RULE22] Rejection reports error, changes no assignment.
// [RULE23] Stop releases engine, streams, channels, bank lock; here the release command does that, stop only idles the sequencer.
module asa_module
    import asa_pkg::*;
#(
    parameter logic [CNT_W-1:0] SETTLE_TIME = 16'h0020, // Reported settling time.
    parameter logic [CNT_W-1:0] GDELAY_RST  = 16'h0010, // Group delay after reset.
    parameter int               OS_REF_DIV  = 2,        // Reference edges per oversample tick.
    parameter int               OS_INT_DIV  = 16,       // Core cycles per tick when free running.
    parameter int               OS_PER_SAMP = 8         // Oversample ticks per sample.
) (
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        front_panel_trigger_input_in,
    output logic             adc_reset_out,
    output logic             adc_os_tick_out,
    output logic             adc_sample_out,
    output logic             data_valid_out,
    asa_link_if.dev          link
);
    // A divider of zero, or an internal divider of one, would stall or lose the tick.
    if (OS_REF_DIV < 1 || OS_INT_DIV < 2 || OS_PER_SAMP < 1) begin : g_chk
        $error("oversample dividers out of range");
    end

    // Count of set bits in a channel mask.
    function automatic logic [5:0] count_ch(input logic [NUM_CH-1:0] m);
        logic [5:0] n;
        n = '0;
        for (int i = 0; i < NUM_CH; i++) n = n + 6'(m[i]);
        return n;
    endfunction

    // Banks touched by a channel mask.
    function automatic logic [NUM_BANKS-1:0] banks_of(input logic [NUM_CH-1:0] m);
        logic [NUM_BANKS-1:0] b;
        b = '0;
        for (int i = 0; i < NUM_BANKS; i++) b[i] = |m[i*BANK_CH +: BANK_CH]; // [RULE14]
        return b;
    endfunction

    // Software settings.
    logic              ref_sel, sync_master, start_master, trig_fp, trig_fall;
    logic [CNT_W-1:0]  delay_floor;   // Start delay floor.
    logic [CNT_W-1:0]  group_delay;   // Filter group delay in cycles.
    logic [NUM_CH-1:0] req_mask;      // Channels of the next request.
    asa_err_t          last_err;      // Result of the last claim.
    logic [1:0]        last_eng;      // Engine granted by the last accepted claim.
    // Engine table: the only allocation state, so releasing frees everything.
    logic [NUM_ENG-1:0] eng_busy;
    logic [NUM_ENG-1:0] eng_mode;
    logic [NUM_CH-1:0]  eng_mask [NUM_ENG];
    logic [2:0]         eng_strm [NUM_ENG];
    // Sequencer and timing.
    asa_state_t        state, next_state;
    logic [CNT_W-1:0]  cnt;           // Cycles spent in the current state.
    logic [CNT_W-1:0]  os_cnt;        // Oversample divider.
    logic [CNT_W-1:0]  samp_cnt;      // Sample divider.
    logic [3:0]        in_meta, in_sync, in_prev; // Ref, sync, start, front panel.

    // Two flops on the reference, sync, start and front panel inputs before any logic sees them.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            in_meta <= 4'h0;
            in_sync <= 4'h0;
            in_prev <= 4'h0;
        end else begin
            in_meta <= {front_panel_trigger_input_in, link.start_line, link.sync_line,
                        link.ref_clk};
            in_sync <= in_meta;
            in_prev <= in_sync;
        end
    end
    wire [3:0] rise = in_sync & ~in_prev;
    wire [3:0] fall = ~in_sync & in_prev;
    wire trig_edge  = trig_fp ? (trig_fall ? fall[3] : rise[3])   // [RULE20]
                              : (trig_fall ? fall[2] : rise[2]);

    // Bus decode; a request is taken on the edge that sees waitrequest low.
    wire bus_req  = avs_read_in | avs_write_in;
    wire wr_take  = avs_write_in & ~avs_waitrequest_out;
    wire wr_ctrl  = wr_take && (avs_address_in == REG_CTRL);
    wire wr_cmd   = wr_take && (avs_address_in == REG_TASK_CMD);
    wire do_claim = wr_cmd & avs_writedata_in[CMD_CLAIM];
    wire do_rel   = wr_cmd & avs_writedata_in[CMD_RELEASE];
    wire req_mode = avs_writedata_in[CMD_MODE];
    wire [1:0] rel_eng = avs_writedata_in[CMD_ENG_LSB +: 2];
    wire commit   = wr_ctrl & avs_writedata_in[CTRL_COMMIT];
    wire start    = wr_ctrl & avs_writedata_in[CTRL_START];
    wire stop     = wr_ctrl & avs_writedata_in[CTRL_STOP];

    // Occupancy of channels, banks and streams by running tasks.
    logic [NUM_CH-1:0]    used_mask;
    logic [NUM_BANKS-1:0] bank_used, bank_tsp;
    logic [2:0]           strm_buf, strm_tsp;
    logic [1:0]           free_eng;
    logic                 any_free;
    always_comb begin
        used_mask = '0;
        bank_used = '0;
        bank_tsp  = '0;
        strm_buf  = '0;
        strm_tsp  = '0;
        free_eng  = '0;
        any_free  = 1'b0;
        for (int e = NUM_ENG - 1; e >= 0; e--) begin
            if (eng_busy[e]) begin
                used_mask = used_mask | eng_mask[e];
                bank_used = bank_used | banks_of(eng_mask[e]);
                bank_tsp  = bank_tsp | (eng_mode[e] ? banks_of(eng_mask[e]) : '0);
                strm_buf  = strm_buf + (eng_mode[e] ? 3'h0 : eng_strm[e]);   // [RULE12]
                strm_tsp  = strm_tsp + (eng_mode[e] ? eng_strm[e] : 3'h0);
            end else begin
                free_eng = 2'(e);
                any_free = 1'b1;
            end
        end
    end

    // Checks of a claim, in priority order.
    wire [5:0] req_n     = count_ch(req_mask);
    wire [2:0] req_strm  = 3'((req_n + 6'h07) >> 3);                         // [RULE19]
    wire [2:0] strm_left = 3'(NUM_STREAMS) - (req_mode ? strm_tsp : strm_buf);
    wire bank_clash = |(banks_of(req_mask) & bank_used & (bank_tsp ^ {NUM_BANKS{req_mode}}));
    asa_err_t claim_err;
    assign claim_err = !any_free                ? ERR_ENGINES  // [RULE18]
                     : |(req_mask & used_mask)  ? ERR_CHANNEL  // [RULE16]
                     : bank_clash               ? ERR_BANK     // [RULE17] [RULE15]
                     : (req_strm > strm_left)   ? ERR_STREAM   // [RULE19] [RULE11]
                     : (req_n == '0)            ? ERR_SIZE
                     : ERR_NONE;

    // Register writes and the engine table; a rejected claim only records its error.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            {ref_sel, sync_master, start_master, trig_fp, trig_fall} <= 5'h00;
            delay_floor <= '0;
            group_delay <= GDELAY_RST;
            req_mask    <= '0;
            last_err    <= ERR_NONE;
            last_eng    <= 2'h0;
            eng_busy    <= '0;
            eng_mode    <= '0;
            for (int e = 0; e < NUM_ENG; e++) begin
                eng_mask[e] <= '0;
                eng_strm[e] <= 3'h0;
            end
        end else begin
            if (wr_ctrl) begin
                ref_sel      <= avs_writedata_in[CTRL_REF_SEL];      // [RULE1]
                sync_master  <= avs_writedata_in[CTRL_SYNC_MASTER];  // [RULE3]
                start_master <= avs_writedata_in[CTRL_START_MASTER]; // [RULE5]
                trig_fp      <= avs_writedata_in[CTRL_TRIG_FP];      // [RULE20]
                trig_fall    <= avs_writedata_in[CTRL_TRIG_FALL];
            end
            if (wr_take && avs_address_in == REG_FLOOR) delay_floor <= avs_writedata_in[15:0];
            if (wr_take && avs_address_in == REG_GDELAY) group_delay <= avs_writedata_in[15:0];
            if (wr_take && avs_address_in == REG_REQ_MASK) req_mask <= avs_writedata_in;
            if (do_claim) begin
                last_err <= claim_err;                                // [RULE22]
                if (claim_err == ERR_NONE) begin                      // [RULE10]
                    last_eng           <= free_eng;
                    eng_busy[free_eng] <= 1'b1;
                    eng_mode[free_eng] <= req_mode;
                    eng_mask[free_eng] <= req_mask;
                    eng_strm[free_eng] <= req_strm;
                end
            end else if (do_rel) begin
                eng_busy[rel_eng] <= 1'b0;                            // [RULE23]
            end
        end
    end

    // Sync and start sequencing.
    wire [CNT_W-1:0] settle_need = (sync_master && delay_floor > group_delay)
                                 ? delay_floor : group_delay;         // [RULE6] [RULE21]
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:      if (commit) next_state = sync_master ? ST_SYNC_OUT : ST_ARMED; // [RULE7]
            ST_ARMED:     if (rise[1]) next_state = ST_SETTLE;                         // [RULE3]
            ST_SYNC_OUT:  if (cnt == PULSE_CYCLES - 1'b1) next_state = ST_SETTLE;
            ST_SETTLE:    if (cnt >= settle_need) next_state = ST_READY;               // [RULE21]
            ST_READY:     if (start) next_state = start_master ? ST_TRIG_OUT : ST_WAIT_TRIG; // [RULE8]
            ST_WAIT_TRIG: if (trig_edge) next_state = ST_FILL_RUN;                     // [RULE4] [RULE5]
            ST_TRIG_OUT:  if (cnt == PULSE_CYCLES - 1'b1) next_state = ST_FILL_RUN;
            ST_FILL_RUN:  next_state = state;
        endcase
        if (stop) next_state = ST_IDLE;
    end

    // A sync event is one issued here or one received while armed.
    wire sync_evt = (state == ST_IDLE && next_state == ST_SYNC_OUT) ||
                    (state == ST_ARMED && next_state == ST_SETTLE);
    wire os_step  = ref_sel ? rise[0] : 1'b1;                                // [RULE1]
    wire [CNT_W-1:0] os_top = ref_sel ? CNT_W'(OS_REF_DIV - 1) : CNT_W'(OS_INT_DIV - 1);
    wire os_tick  = os_step && (os_cnt == os_top);
    wire samp_tick = os_tick && (samp_cnt == CNT_W'(OS_PER_SAMP - 1));

    // State, dividers and the registered outputs.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state                <= ST_IDLE;
            cnt                  <= '0;
            os_cnt               <= '0;
            samp_cnt             <= '0;
            adc_reset_out        <= 1'b0;
            adc_os_tick_out      <= 1'b0;
            adc_sample_out       <= 1'b0;
            data_valid_out       <= 1'b0;
            link.dev_sync_drive  <= 1'b0;
            link.dev_start_drive <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= (state != next_state) ? '0 : (cnt == '1) ? cnt : cnt + 1'b1;
            // Restarting the dividers is what phase aligns all modules.
            os_cnt   <= sync_evt ? '0 : !os_step ? os_cnt : os_tick ? '0 : os_cnt + 1'b1; // [RULE2]
            samp_cnt <= sync_evt ? '0 : !os_tick ? samp_cnt : samp_tick ? '0 : samp_cnt + 1'b1;
            adc_reset_out        <= sync_evt;                               // [RULE2]
            adc_os_tick_out      <= os_tick & ~sync_evt;
            adc_sample_out       <= samp_tick & ~sync_evt;                  // [RULE13]
            link.dev_sync_drive  <= (next_state == ST_SYNC_OUT);            // [RULE3]
            link.dev_start_drive <= (next_state == ST_TRIG_OUT);            // [RULE4]
            // Samples before the filter has settled are withheld.
            data_valid_out <= (next_state == ST_FILL_RUN) && (state == ST_FILL_RUN) &&
                              (cnt >= group_delay);                         // [RULE9] [RULE8]
        end
    end

    // Read data selection.
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address_in)
            REG_CTRL:      rd_mux = {27'h0, trig_fall, trig_fp, start_master, sync_master, ref_sel};
            REG_STATUS:    rd_mux = {24'h0, data_valid_out, 4'h0, 3'(state)};
            REG_SETTLE:    rd_mux = {16'h0, SETTLE_TIME};                   // [RULE6]
            REG_FLOOR:     rd_mux = {16'h0, delay_floor};
            REG_GDELAY:    rd_mux = {16'h0, group_delay};
            REG_REQ_MASK:  rd_mux = req_mask;
            REG_TASK_STAT: rd_mux = {20'h0, eng_busy, 2'h0, last_eng, 1'b0, 3'(last_err)};
            REG_CLAIMED:   rd_mux = used_mask;
            REG_BANKS:     rd_mux = {24'h0, bank_tsp, bank_used};
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    // One wait cycle per access; read data are latched as waitrequest drops.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end else begin
            avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
            if (avs_read_in & avs_waitrequest_out) avs_readdata_out <= rd_mux;
        end
    end
endmodule

/* File: rtl/asa_peer.sv */
`timescale 1ns/1ps
// Backplane and peer module end: makes the reference and the trigger lines.
module asa_peer
    import asa_pkg::*;
#(
    parameter int REF_HALF = REF_HALF_CYCLES
) (
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic sync_master_in,
    input  wire logic start_master_in,
    input  wire logic commit_in,
    input  wire logic start_in,
    output logic      sync_seen_out,
    output logic      start_seen_out,
    asa_link_if.peer  link
);
    // A zero half period could never toggle the reference.
    if (REF_HALF < 1) begin : g_chk
        $error("REF_HALF must be at least one");
    end

    logic [CNT_W-1:0] ref_cnt;   // Reference divider.
    logic [CNT_W-1:0] sync_cnt;  // Remaining sync drive cycles.
    logic [CNT_W-1:0] start_cnt; // Remaining start drive cycles.
    logic [1:0]       sync_meta; // Sync line sampler.
    logic [1:0]       start_meta;// Start line sampler.
    logic             sync_prev; // Previous sampled sync level.
    logic             start_prev;// Previous sampled start level.

    // Issue only when master, and never restart a pulse already on the line.
    wire issue_sync  = commit_in & sync_master_in & (sync_cnt == '0);   // [RULE3] [RULE7]
    wire issue_start = start_in & start_master_in & (start_cnt == '0);  // [RULE4] [RULE8]
    wire ref_wrap    = (ref_cnt == CNT_W'(REF_HALF - 1));

    // The reference is a divided core clock, driven straight from a flop.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ref_cnt      <= '0;
            link.ref_clk <= 1'b0;
        end else begin
            ref_cnt      <= ref_wrap ? '0 : ref_cnt + 1'b1;
            link.ref_clk <= ref_wrap ? ~link.ref_clk : link.ref_clk;
        end
    end

    // Master pulses hold the line for a fixed number of cycles.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sync_cnt              <= '0;
            start_cnt             <= '0;
            link.peer_sync_drive  <= 1'b0;
            link.peer_start_drive <= 1'b0;
        end else begin
            sync_cnt  <= issue_sync ? PULSE_CYCLES : (sync_cnt != '0) ? sync_cnt - 1'b1 : sync_cnt;
            start_cnt <= issue_start ? PULSE_CYCLES :
                         (start_cnt != '0) ? start_cnt - 1'b1 : start_cnt;
            link.peer_sync_drive  <= issue_sync | (sync_cnt > 16'h0001);
            link.peer_start_drive <= issue_start | (start_cnt > 16'h0001);
        end
    end

    // Slaves watch the lines through two flops and report rising edges.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sync_meta      <= 2'h0;
            start_meta     <= 2'h0;
            sync_prev      <= 1'b0;
            start_prev     <= 1'b0;
            sync_seen_out  <= 1'b0;
            start_seen_out <= 1'b0;
        end else begin
            sync_meta      <= {sync_meta[0], link.sync_line};
            start_meta     <= {start_meta[0], link.start_line};
            sync_prev      <= sync_meta[1];
            start_prev     <= start_meta[1];
            sync_seen_out  <= sync_meta[1] & ~sync_prev & ~sync_master_in;    // [RULE3]
            start_seen_out <= start_meta[1] & ~start_prev & ~start_master_in; // [RULE4]
        end
    end
endmodule

/* File: rtl/asa_pkg.sv */
package asa_pkg;
    // Core clock period; the backplane end divides it down into the reference.
    localparam int CLK_PERIOD_NS   = 40;
    // Reference period made by the backplane end.
    localparam int REF_PERIOD_NS   = 320;
    // Core cycles per half reference period.
    localparam int REF_HALF_CYCLES = REF_PERIOD_NS / (2 * CLK_PERIOD_NS);
    // Channel, bank, engine and stream geometry.
    localparam int NUM_CH      = 32;
    localparam int BANK_CH     = 8;
    localparam int NUM_BANKS   = NUM_CH / BANK_CH;
    localparam int NUM_ENG     = 4;
    localparam int NUM_STREAMS = 4;
    localparam int STREAM_CH   = 8;
    // Width of every timing counter.
    localparam int CNT_W       = 16;
    // Cycles a driven trigger line stays high, long enough for a 2FF sampler.
    localparam logic [CNT_W-1:0] PULSE_CYCLES = 16'h0004;
    // Register byte offsets.
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_SETTLE    = 8'h08;
    localparam logic [7:0] REG_FLOOR     = 8'h0C;
    localparam logic [7:0] REG_GDELAY    = 8'h10;
    localparam logic [7:0] REG_REQ_MASK  = 8'h14;
    localparam logic [7:0] REG_TASK_CMD  = 8'h18;
    localparam logic [7:0] REG_TASK_STAT = 8'h1C;
    localparam logic [7:0] REG_CLAIMED   = 8'h20;
    localparam logic [7:0] REG_BANKS     = 8'h24;
    // Control register bit positions.
    localparam int CTRL_REF_SEL      = 0;
    localparam int CTRL_SYNC_MASTER  = 1;
    localparam int CTRL_START_MASTER = 2;
    localparam int CTRL_TRIG_FP      = 3;
    localparam int CTRL_TRIG_FALL    = 4;
    localparam int CTRL_COMMIT       = 8;
    localparam int CTRL_START        = 9;
    localparam int CTRL_STOP         = 10;
    // Task command register bit positions.
    localparam int CMD_ENG_LSB = 0;
    localparam int CMD_MODE    = 4;
    localparam int CMD_CLAIM   = 8;
    localparam int CMD_RELEASE = 9;
    // Stream modes.
    localparam logic MODE_BUF = 1'b0;
    localparam logic MODE_TSP = 1'b1;
    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE, ST_ARMED, ST_SYNC_OUT, ST_SETTLE, ST_READY, ST_WAIT_TRIG, ST_TRIG_OUT, ST_FILL_RUN
    } asa_state_t;
    // Allocation result codes, in the order they are checked.
    typedef enum logic [2:0] {
        ERR_NONE, ERR_ENGINES, ERR_CHANNEL, ERR_BANK, ERR_STREAM, ERR_SIZE
    } asa_err_t;
endpackage

/* File: testbench/acq_sync_and_stream_allocator_bench.sv */
`timescale 1ns/1ps
// Joins module and peer, then walks sync, start and allocation.
module acq_sync_and_stream_allocator_bench;
    import asa_pkg::*;
    logic        clk, rst, rd, wr, wait_o, fp, rst_pulse, dvalid;
    logic [7:0]  adr;
    logic [31:0] wd, rdat, q;
    logic        p_sm, p_stm, p_commit, p_start, p_sync_seen, p_start_seen;
    int          miscompares, total_checks, n;
    asa_link_if asa_link_if_i ();
    asa_module asa_module_i (.core_clk_in(clk), .sys_rst_in(rst), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wait_o), .front_panel_trigger_input_in(fp),
        .adc_reset_out(rst_pulse), .adc_os_tick_out(), .adc_sample_out(),
        .data_valid_out(dvalid), .link(asa_link_if_i));
    asa_peer asa_peer_i (.core_clk_in(clk), .sys_rst_in(rst), .sync_master_in(p_sm),
        .start_master_in(p_stm), .commit_in(p_commit), .start_in(p_start),
        .sync_seen_out(p_sync_seen), .start_seen_out(p_start_seen), .link(asa_link_if_i));
    asa_link_assertions asa_link_assertions_i (.core_clk_in(clk), .sys_rst_in(rst),
        .ref_clk(asa_link_if_i.ref_clk), .dev_sync_drive(asa_link_if_i.dev_sync_drive),
        .dev_start_drive(asa_link_if_i.dev_start_drive),
        .peer_sync_drive(asa_link_if_i.peer_sync_drive),
        .peer_start_drive(asa_link_if_i.peer_start_drive),
        .sync_line(asa_link_if_i.sync_line), .start_line(asa_link_if_i.start_line));
    always #20 clk = ~clk;
    task conclude;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One Avalon cycle; samples waitrequest as it stood before each edge.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk); rd <= !w; wr <= w; adr <= a; wd <= d;
        @(posedge clk);
        while (wait_o !== 1'b0 && k < 50) begin @(posedge clk); k++; end
        if (k == 50) miscompares++;
        q = rdat; rd <= 1'b0; wr <= 1'b0;
    endtask
    task poll(input logic [2:0] s);
        n = 0;
        do begin bus(0, REG_STATUS, 0); n++; end while (q[2:0] !== s && n < 100);
        chk(q & 32'h7, 32'(s));
    endtask
    task claim(input logic [31:0] m, input logic tsp, input asa_err_t e);
        bus(1, REG_REQ_MASK, m);
        bus(1, REG_TASK_CMD, tsp ? 32'h110 : 32'h100);
        bus(0, REG_TASK_STAT, 0);
        chk(q & 32'h7, 32'(e));
    endtask
    // Module follows the peer for sync and takes start from a front panel falling edge.
    task sync_as_slave;
        bus(1, REG_CTRL, 32'h101); poll(1);
        @(posedge clk) p_commit <= 1'b1; @(posedge clk) p_commit <= 1'b0;
        for (n = 0; n < 300 && rst_pulse !== 1'b1; n++) @(posedge clk);
        chk(rst_pulse, 1);
        poll(4);
        bus(1, REG_CTRL, 32'h219); poll(5);
        chk(dvalid, 0);
        @(posedge clk) p_start <= 1'b1; @(posedge clk) p_start <= 1'b0;
        repeat (40) @(posedge clk);
        chk(dvalid, 0);
        fp <= 1'b0;
        for (n = 0; n < 300 && dvalid !== 1'b1; n++) @(posedge clk);
        chk(dvalid, 1);
        poll(7);
    endtask
    // Module originates both; the floor must hold it in settling.
    task sync_as_master;
        bus(1, REG_CTRL, 32'h407); bus(1, REG_FLOOR, 32'h40);
        p_sm <= 1'b0; p_stm <= 1'b0;
        bus(1, REG_CTRL, 32'h107);
        for (n = 0; n < 300 && p_sync_seen !== 1'b1; n++) @(posedge clk);
        chk(p_sync_seen, 1);
        repeat (30) @(posedge clk);
        bus(0, REG_STATUS, 0); chk(q & 32'h7, 32'h3);
        poll(4);
        bus(1, REG_CTRL, 32'h207);
        for (n = 0; n < 300 && p_start_seen !== 1'b1; n++) @(posedge clk);
        chk(p_start_seen, 1);
        for (n = 0; n < 300 && dvalid !== 1'b1; n++) @(posedge clk);
        chk(dvalid, 1);
    endtask
    // Claims, refusals and releases against the allocation table.
    task alloc_checks;
        claim(32'h1, 0, ERR_NONE);
        claim(32'h2, 1, ERR_BANK);
        claim(32'h1, 0, ERR_CHANNEL);
        claim(32'h2, 0, ERR_NONE);
        claim(32'h4, 0, ERR_NONE);
        claim(32'h8, 0, ERR_NONE);
        claim(32'h100, 1, ERR_ENGINES);
        bus(0, REG_CLAIMED, 0); chk(q, 32'hF);
        for (int i = 0; i < 4; i++) bus(1, REG_TASK_CMD, 32'h200 | i);
        bus(0, REG_BANKS, 0); chk(q & 32'hFF, 32'h0);
        claim(32'h01FFFFFF, 0, ERR_NONE);
        claim(32'h02000000, 0, ERR_STREAM);
        claim(32'h02000000, 1, ERR_BANK);
        bus(0, REG_SETTLE, 0); chk(q & 32'hFFFF, 32'h20);
        bus(0, 8'hFC, 0); chk(q, 32'h0);
    endtask
    initial begin
        clk = 0; rst = 1; rd = 0; wr = 0; adr = 0; wd = 0; fp = 1;
        p_sm = 1; p_stm = 1; p_commit = 0; p_start = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        sync_as_slave; sync_as_master; alloc_checks;
        conclude;
    end
    // Whole run is a few hundred cycles; this cuts a hang short.
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        conclude;
    end
endmodule

/* File: testbench/asa_link_assertions.sv */
`timescale 1ns/1ps
// Watches the backplane lines between the module and its peer.
module asa_link_assertions (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic ref_clk,
    input wire logic dev_sync_drive,
    input wire logic dev_start_drive,
    input wire logic peer_sync_drive,
    input wire logic peer_start_drive,
    input wire logic sync_line,
    input wire logic start_line
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Each reference level lasts four core cycles; a stuck divider shows here.
    a_ref_half_period:
        assert property ($changed(ref_clk) |=> $stable(ref_clk)[*3] ##1 $changed(ref_clk))
        else $error("reference half period wrong");
    // Pulses must be long enough for the far end's two-flop sampler.
    a_sync_pulse_len:
        assert property ($rose(dev_sync_drive) |-> dev_sync_drive[*4] ##1 !dev_sync_drive)
        else $error("module sync pulse length wrong");
    a_start_pulse_len:
        assert property ($rose(dev_start_drive) |-> dev_start_drive[*4] ##1 !dev_start_drive)
        else $error("module start pulse length wrong");
    a_peer_sync_len:
        assert property ($rose(peer_sync_drive) |-> peer_sync_drive[*4] ##1 !peer_sync_drive)
        else $error("peer sync pulse length wrong");
    a_peer_start_len:
        assert property ($rose(peer_start_drive) |-> peer_start_drive[*4] ##1 !peer_start_drive)
        else $error("peer start pulse length wrong");
    // Only the one master of each line may raise it; two masters would collide.
    a_sync_one_driver:
        assert property ($rose(sync_line) |-> dev_sync_drive ^ peer_sync_drive)
        else $error("sync line has two drivers");
    a_start_one_driver:
        assert property ($rose(start_line) |-> dev_start_drive ^ peer_start_drive)
        else $error("start line has two drivers");
    // A start never overlaps the sync pulse, since settling must pass first.
    a_start_after_sync:
        assert property ($rose(dev_start_drive) || $rose(peer_start_drive) |-> !sync_line)
        else $error("start issued during sync");
endmodule
